// File: bench/bus_slave_model.sv
/* Bus slave model facing the bridge master port.
 * Assumes the bridge holds a command while waitreq is high. */
`timescale 1ns/1ps
module bus_slave_model (
	// Clock
	input  wire logic        i_core_clk,
	// Read command
	input  wire logic        i_mr_valid,
	input  wire logic [31:0] i_mr_addr,
	input  wire logic [6:0]  i_mr_burst,
	// Answer
	output logic             o_waitreq,
	output logic             o_rvalid = 1'b0,
	output logic [63:0]      o_rdata  = '0
);
	logic [31:0] addr_q = '0;
	logic [6:0]  left_q = '0;
	logic        slow_q = '0;

	// Busy during a burst, so no command is lost
	assign o_waitreq = slow_q || left_q != 7'h00;

	always_ff @(posedge i_core_clk)
	begin
		slow_q   <= !slow_q;
		o_rvalid <= left_q != 7'h00;
		o_rdata  <= left_q != 7'h00 ? {32'h0000_0000, addr_q} : ~o_rdata;
		if (left_q != 7'h00)
		begin
			addr_q <= addr_q + 32'h0000_0008;
			left_q <= left_q - 7'h01;
		end
		else if (i_mr_valid && !o_waitreq)
		begin
			addr_q <= i_mr_addr;
			left_q <= i_mr_burst;
		end
	end
endmodule // bus_slave_model

// File: bench/membus_bridge_sva.sv
/* Port checker of the bridge data path.
 * Assumes the bind below and a single clock. */
`timescale 1ns/1ps
module membus_bridge_sva
	import membus_bridge_pkg::*;
#(
	parameter int MPS_BYTES = 128
) (
	// Clock and reset
	input wire logic                        i_core_clk,
	input wire logic                        i_reset_n,
	// Read requests
	input wire logic                        o_rq_valid,
	input wire membus_bridge_pkg::rd_req_t  o_rq,
	input wire logic                        i_rq_ready,
	// Bus master
	input wire logic                        o_mr_valid,
	input wire logic [6:0]                  o_mr_burst,
	input wire logic                        o_mw_valid,
	input wire logic [31:0]                 o_mw_addr,
	input wire logic [63:0]                 o_mw_data,
	input wire logic [7:0]                  o_mw_be,
	input wire logic                        i_mw_waitreq,
	// Completions
	input wire logic                        o_tc_valid,
	input wire logic                        o_tc_sop,
	input wire membus_bridge_pkg::cpl_hdr_t o_tc_hdr,
	input wire logic [63:0]                 o_tc_data,
	input wire logic                        i_tc_ready,
	input wire logic                        i_cpl_hdr_credit
);
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (!i_reset_n);
	logic [3:0] tag_q;
	logic       seen_q;

	always_ff @(posedge i_core_clk)
	begin
		if (!i_reset_n)
			seen_q <= 1'b0;
		else if (o_rq_valid && i_rq_ready)
		begin
			seen_q <= 1'b1;
			tag_q  <= o_rq.tag;
		end
	end

	sequence s_rq_go; o_rq_valid && i_rq_ready; endsequence
	sequence s_tc_hdr; o_tc_valid && o_tc_sop && i_tc_ready; endsequence
	property p_rq_size; o_rq_valid |-> o_rq.len_dw != 0 && o_rq.len_dw <= 10'h040; endproperty
	property p_rq_4k;
		o_rq_valid |-> 14'(o_rq.addr[11:0]) + 14'(o_rq.len_dw) * 4 <= 14'h1000;
	endproperty
	property p_tag; s_rq_go ##0 seen_q |-> o_rq.tag == tag_q + 4'h1; endproperty
	property p_rq_hold; o_rq_valid && !i_rq_ready |=> o_rq_valid && $stable(o_rq); endproperty
	property p_mr_burst; o_mr_valid |-> o_mr_burst != 0 && o_mr_burst <= 7'h40; endproperty
	property p_mw_hold;
		o_mw_valid && i_mw_waitreq |=> o_mw_valid && $stable({o_mw_addr, o_mw_data, o_mw_be});
	endproperty
	property p_tc_hold;
		o_tc_valid && !i_tc_ready |=> o_tc_valid && $stable({o_tc_sop, o_tc_data});
	endproperty
	property p_tc_size;
		o_tc_valid && o_tc_sop |-> o_tc_hdr.len_dw != 0 && o_tc_hdr.len_dw <= MPS_BYTES / 4;
	endproperty
	// No header may start while the link partner has no header credit
	property p_tc_credit;
		!i_cpl_hdr_credit && !o_tc_valid |=> !(o_tc_valid && o_tc_sop);
	endproperty
	property p_tc_data; s_tc_hdr |=> ##[0:16] (o_tc_valid && !o_tc_sop); endproperty

	a_rq_size:
		assert property (p_rq_size) else $error("read request too long");
	a_rq_4k:
		assert property (p_rq_4k) else $error("read request crosses 4K");
	a_tag:
		assert property (p_tag) else $error("tag not sequential");
	a_rq_hold:
		assert property (p_rq_hold) else $error("read request not held");
	a_mr_burst:
		assert property (p_mr_burst) else $error("bus read burst too long");
	a_mw_hold:
		assert property (p_mw_hold) else $error("write beat not held");
	a_tc_hold:
		assert property (p_tc_hold) else $error("completion beat not held");
	a_tc_size:
		assert property (p_tc_size) else $error("completion over payload size");
	a_tc_credit:
		assert property (p_tc_credit) else $error("completion sent without credit");
	a_tc_data:
		assert property (p_tc_data) else $error("completion header without data");
endmodule // membus_bridge_sva

bind membus_bridge membus_bridge_sva #(.MPS_BYTES(MPS_BYTES)) u_sva (.*);

// File: bench/tb.sv
/* Self-checking bench of the bridge data path.
 * Assumes the bus slave model and the checker bind. */
`timescale 1ns/1ps
module tb;
	import membus_bridge_pkg::*;
	localparam logic [191:0] XLAT = {128'h0, 32'hABC0_0000, 32'h5550_0000};
	logic        i_core_clk = '0, i_reset_n = '0, i_sr_valid = '0, i_np_hdr_credit = '0;
	logic        i_rq_ready = '0, i_in_valid = '0, i_cpl_hdr_credit = '0, i_tc_ready = '0;
	logic [31:0] i_sr_addr = '0;
	logic [9:0]  i_sr_qwords = '0;
	logic [7:0]  i_cpl_data_credit = '0;
	in_word_t    i_in_word = '0;
	logic        o_sr_ready, o_rd_valid, o_rq_valid, o_in_ready, o_mw_valid, o_mr_valid;
	logic        o_tc_valid, o_tc_sop, i_mw_waitreq, i_mr_rvalid;
	logic [63:0] o_rd_data, o_mw_data, o_tc_data, i_mr_rdata;
	logic [31:0] o_mw_addr, o_mr_addr;
	logic [6:0]  o_mw_burst, o_mr_burst;
	logic [7:0]  o_mw_be;
	rd_req_t     o_rq;
	cpl_hdr_t    o_tc_hdr;
	wire         i_mr_waitreq = i_mw_waitreq;
	int          num_errors = 0, n_checks = 0, cyc = 0;

	always #12.5 i_core_clk = ~i_core_clk;

	membus_bridge #(.XLAT_TABLE(XLAT)) dut (.*);
	bus_slave_model slave (.i_core_clk(i_core_clk), .i_mr_valid(o_mr_valid),
		.i_mr_addr(o_mr_addr), .i_mr_burst(o_mr_burst), .o_waitreq(i_mw_waitreq),
		.o_rvalid(i_mr_rvalid), .o_rdata(i_mr_rdata));

	////////////////////////////////////////////////////////////////////////////////

	task automatic check(input logic [63:0] got, input logic [63:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			num_errors++;
			$display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic wrap_up();
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task automatic push(input in_word_t w);
		i_in_valid <= 1'b1;
		i_in_word  <= w;
		@(posedge i_core_clk);
		while (!o_in_ready)
			@(posedge i_core_clk);
	endtask

	task automatic t_out_read();
		rd_req_t  q[$];
		in_word_t w;
		int       n, t;
		i_sr_addr   <= 32'h0000_0F80;
		i_sr_qwords <= 10'h040;
		i_sr_valid  <= 1'b1;
		@(posedge i_core_clk);
		while (!o_sr_ready)
			@(posedge i_core_clk);
		i_sr_valid <= 1'b0;
		repeat (20) @(posedge i_core_clk);
		check(o_rq_valid, '0);
		i_np_hdr_credit <= 1'b1;
		while (q.size() < 3 && t++ < 200)
		begin
			@(posedge i_core_clk);
			if (o_rq_valid && i_rq_ready)
				q.push_back(o_rq);
			i_rq_ready <= !i_rq_ready;
		end
		check(q[0], {32'h0000_0F80, 10'h020, 4'h0});
		check(q[1], {32'h0000_1000, 10'h040, 4'h1});
		check(q[2], {32'h0000_1100, 10'h020, 4'h2});
		t = 0;
		fork
			begin
				// Newest first, so reordering is needed
				for (int k = 2; k >= 0; k--)
				begin
					w = '0;
					w.sop = 1'b1;
					w.hdr.kind = TLP_CPL;
					w.hdr.tag = {4'h0, q[k].tag};
					w.hdr.len_dw = q[k].len_dw;
					push(w);
					w.sop = 1'b0;
					for (int j = 0; j < q[k].len_dw / 2; j++)
					begin
						w.data = 64'(q[k].addr + 8 * j);
						push(w);
					end
				end
				// Release right after the last word, not at the next task's start
				i_in_valid <= 1'b0;
			end
			while (n < 64 && t++ < 3000)
			begin
				@(posedge i_core_clk);
				if (o_rd_valid)
				begin
					check(o_rd_data, 64'(32'h0000_0F80 + 8 * n));
					n++;
				end
			end
		join
		check(n, 64);
	endtask

	task automatic t_in_write();
		in_word_t w;
		int       n, t;
		w = '0;
		w.sop = 1'b1;
		w.hdr.kind = TLP_WR;
		w.hdr.bar = 3'h1;
		w.hdr.addr = 32'h1234_5670;
		w.hdr.len_dw = 10'h004;
		w.hdr.first_dword_byte_mask = 4'hE;
		w.hdr.last_dword_byte_mask = 4'h3;
		fork
			begin
				push(w);
				w.sop = 1'b0;
				w.data = {2{32'h1111_1111}};
				push(w);
				w.data = {2{32'h2222_2222}};
				push(w);
				i_in_valid <= 1'b0;
			end
			while (n < 2 && t++ < 500)
			begin
				@(posedge i_core_clk);
				if (o_mw_valid && !i_mw_waitreq)
				begin
					if (n == 0)
						check({o_mw_addr, o_mw_burst}, {32'hABC4_5670, 7'h02});
					check(o_mw_data, {2{n ? 32'h2222_2222 : 32'h1111_1111}});
					check(o_mw_be, n ? 8'h3F : 8'hFE);
					n++;
				end
			end
		join
		check(n, 2);
	endtask

	task automatic t_in_read();
		in_word_t w;
		int       h, d, t;
		w = '0;
		w.sop = 1'b1;
		w.hdr.kind = TLP_RD;
		w.hdr.tag = 8'h05;
		w.hdr.req_id = 16'hBEEF;
		w.hdr.addr = 32'h0000_0040;
		w.hdr.len_dw = 10'h040;
		push(w);
		i_in_valid <= 1'b0;
		repeat (60) @(posedge i_core_clk);
		check(o_tc_valid, '0);
		i_cpl_hdr_credit  <= 1'b1;
		i_cpl_data_credit <= 8'h10;
		while (h + d < 34 && t++ < 2000)
		begin
			@(posedge i_core_clk);
			if (o_tc_valid && i_tc_ready && o_tc_sop)
			begin
				check(o_tc_hdr, {16'hBEEF, 8'h05, 10'h020, 12'h100 - 12'(h * 128), 7'h40});
				h++;
			end
			else if (o_tc_valid && i_tc_ready)
			begin
				check(o_tc_data, 64'(32'h5550_0040 + 8 * d));
				d++;
			end
			i_tc_ready <= !i_tc_ready;
		end
		check({h, d}, {32'd2, 32'd32});
	endtask

	initial
	begin
		repeat (6) @(posedge i_core_clk);
		i_reset_n <= 1'b1;
		repeat (2) @(posedge i_core_clk);
		t_out_read();
		t_in_write();
		t_in_read();
		wrap_up();
	end

	always @(posedge i_core_clk)
	begin
		cyc++;
		if (cyc > 20000)
		begin
			num_errors++;
			wrap_up();
		end
	end
endmodule // tb

// File: verilog/membus_bridge.sv
/*
 * Bridge data path: bus reads to link read requests, link completions back in
 * issue order, inbound link writes and reads onto the bus master port, and
 * completions built from bus read data. Also holds the generic FIFO used in it.
 * Assumes one clock for link and bus sides; credit inputs are levels from the
 * transaction layer; bus read data cannot be stalled.
 */
`timescale 1ns/1ps
`include "membus_bridge_map.svh"

module bridge_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = `QUEUE_DEPTH
) (
	// Clock and reset
	input  wire logic             i_core_clk,
	input  wire logic             i_reset_n,
	// Fill side
	input  wire logic             i_in_valid,
	input  wire logic [WIDTH-1:0] i_in_data,
	output logic                  o_in_ready,
	// Drain side
	output logic                  o_out_valid,
	output logic      [WIDTH-1:0] o_out_data,
	input  wire logic             i_out_ready
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_q;
	logic [AW-1:0]    rd_q;
	logic [AW:0]      count_q;
	logic [AW:0]      count_d;
	logic             push;
	logic             pop;

	assign push = i_in_valid && o_in_ready;
	assign pop = o_out_valid && i_out_ready;
	assign count_d = count_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
	assign o_out_data = mem[rd_q];

	always_ff @(posedge i_core_clk)
	begin
		if (push)
			mem[wr_q] <= i_in_data;
	end

	// Flags are registered so the ready seen outside is a flop
	always_ff @(posedge i_core_clk)
	begin
		if (!i_reset_n)
		begin
			wr_q        <= '0;
			rd_q        <= '0;
			count_q     <= '0;
			o_in_ready  <= 1'b1;
			o_out_valid <= 1'b0;
		end
		else
		begin
			wr_q        <= push ? wr_q + 1'b1 : wr_q;
			rd_q        <= pop ? rd_q + 1'b1 : rd_q;
			count_q     <= count_d;
			o_in_ready  <= count_d != DEPTH[AW:0];
			o_out_valid <= count_d != '0;
		end
	end
endmodule // bridge_fifo

////////////////////////////////////////////////////////////////////////////////

module membus_bridge
	import membus_bridge_pkg::*;
#(
	parameter int               MPS_BYTES  = `MPS_BYTES,
	parameter logic [6*32-1:0]  XLAT_TABLE = '0
) (
	// Clock and reset
	input  wire logic                        i_core_clk,
	input  wire logic                        i_reset_n,
	// Bus slave read port (outbound reads)
	input  wire logic                        i_sr_valid,
	input  wire logic [31:0]                 i_sr_addr,
	input  wire logic [9:0]                  i_sr_qwords,
	output logic                             o_sr_ready,
	output logic                             o_rd_valid,
	output logic [63:0]                      o_rd_data,
	// Outbound read requests to the transaction layer
	input  wire logic                        i_np_hdr_credit,
	output logic                             o_rq_valid,
	output membus_bridge_pkg::rd_req_t       o_rq,
	input  wire logic                        i_rq_ready,
	// Inbound packet words from the transaction layer
	input  wire logic                        i_in_valid,
	input  wire membus_bridge_pkg::in_word_t i_in_word,
	output logic                             o_in_ready,
	// Bus master port
	output logic                             o_mw_valid,
	output logic [31:0]                      o_mw_addr,
	output logic [6:0]                       o_mw_burst,
	output logic [63:0]                      o_mw_data,
	output logic [7:0]                       o_mw_be,
	input  wire logic                        i_mw_waitreq,
	output logic                             o_mr_valid,
	output logic [31:0]                      o_mr_addr,
	output logic [6:0]                       o_mr_burst,
	input  wire logic                        i_mr_waitreq,
	input  wire logic                        i_mr_rvalid,
	input  wire logic [63:0]                 i_mr_rdata,
	// Outbound completions to the transaction layer
	input  wire logic                        i_cpl_hdr_credit,
	input  wire logic [7:0]                  i_cpl_data_credit,
	output logic                             o_tc_valid,
	output logic                             o_tc_sop,
	output membus_bridge_pkg::cpl_hdr_t      o_tc_hdr,
	output logic [63:0]                      o_tc_data,
	input  wire logic                        i_tc_ready
);
	localparam logic [6:0] MPS_QW = 7'(MPS_BYTES / 8);
	localparam logic [31:0] KEEP_MASK = (32'h1 << `XLAT_KEEP_BITS) - 32'h1;

	typedef enum {D_HDR, D_CPL, D_WR} disp_t;
	typedef enum {T_IDLE, T_DATA} txs_t;

	function automatic logic [31:0] xlat(input logic [31:0] a, input logic [2:0] bar);
		xlat = (XLAT_TABLE[bar*32 +: 32] & ~KEEP_MASK) | (a & KEEP_MASK);
	endfunction

	function automatic logic [6:0] qw_of(input logic [31:0] a, input logic [9:0] dw);
		qw_of = 7'(({1'b0, dw} + {10'h0, a[2]} + 11'h1) >> 1);
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Outbound read splitting into the bypass queue

	logic        sp_busy_q;
	logic [31:0] sp_addr_q;
	logic [12:0] sp_rem_q;
	logic [12:0] to_bnd;
	logic [12:0] chunk;
	logic        byp_in_ready;
	logic        byp_valid;
	rd_req_t     byp_head;
	logic        issue;

	assign to_bnd = `ADDR_BOUNDARY - {1'b0, sp_addr_q[11:0]};
	always_comb
	begin
		chunk = sp_rem_q;
		if (chunk > `RQ_MAX_BYTES)
			chunk = `RQ_MAX_BYTES;
		if (chunk > to_bnd)
			chunk = to_bnd;
	end

	// Multi-beat reads are fetched whole; all lanes assumed enabled
	always_ff @(posedge i_core_clk)
	begin
		if (!i_reset_n)
		begin
			sp_busy_q  <= 1'b0;
			sp_addr_q  <= '0;
			sp_rem_q   <= '0;
			o_sr_ready <= 1'b0;
		end
		else if (!sp_busy_q)
		begin
			o_sr_ready <= !(i_sr_valid && o_sr_ready) && i_sr_qwords != '0;
			if (i_sr_valid && o_sr_ready && i_sr_qwords != '0)
			begin
				sp_busy_q <= 1'b1;
				sp_addr_q <= {i_sr_addr[31:3], 3'b000};
				sp_rem_q  <= {i_sr_qwords, 3'b000};
			end
		end
		else if (byp_in_ready)
		begin
			sp_addr_q <= sp_addr_q + {19'h0, chunk};
			sp_rem_q  <= sp_rem_q - chunk;
			if (sp_rem_q == chunk)
			begin
				sp_busy_q  <= 1'b0;
				o_sr_ready <= 1'b1;
			end
		end
	end

	// Reads wait here until issuable, leaving the command path free
	bridge_fifo #(.WIDTH($bits(rd_req_t)), .DEPTH(`QUEUE_DEPTH)) u_bypass (
		.i_core_clk  (i_core_clk),
		.i_reset_n   (i_reset_n),
		.i_in_valid  (sp_busy_q),
		.i_in_data   ({sp_addr_q, chunk[11:2], 4'h0}),
		.o_in_ready  (byp_in_ready),
		.o_out_valid (byp_valid),
		.o_out_data  (byp_head),
		.i_out_ready (issue)
	);

	////////////////////////////////////////////////////////////////////////////
	// Tag issue, tag memory, completion receive and in-order return

	logic [5:0]  tag_len  [`TAG_COUNT];
	logic [6:0]  tag_base [`TAG_COUNT];
	logic [5:0]  tag_recv [`TAG_COUNT];
	logic [63:0] rx_mem   [`RX_MEM_WORDS];
	logic [3:0]  tag_ctr_q;
	logic [4:0]  tags_used_q;
	logic [7:0]  rx_free_q;
	logic [6:0]  rx_alloc_q;
	logic [3:0]  hol_q;
	logic [5:0]  dlv_q;
	logic        deliver;
	logic        retire;
	logic [5:0]  byp_qw;

	assign byp_qw = byp_head.len_dw[6:1];
	assign issue = byp_valid && i_np_hdr_credit && tags_used_q != 5'd16
		&& rx_free_q >= {2'b00, byp_qw} && (!o_rq_valid || i_rq_ready);
	assign deliver = tags_used_q != '0 && dlv_q != tag_recv[hol_q];
	assign retire = deliver && dlv_q + 6'd1 == tag_len[hol_q];

	always_ff @(posedge i_core_clk)
	begin
		if (!i_reset_n)
		begin
			o_rq_valid <= 1'b0;
			o_rq       <= '0;
			tag_ctr_q  <= '0;
			rx_alloc_q <= '0;
		end
		else
		begin
			if (i_rq_ready)
				o_rq_valid <= 1'b0;
			if (issue)
			begin
				o_rq_valid <= 1'b1;
				o_rq       <= {byp_head.addr, byp_head.len_dw, tag_ctr_q};
				tag_ctr_q  <= tag_ctr_q + 4'd1;
				rx_alloc_q <= rx_alloc_q + {1'b0, byp_qw};
			end
		end
	end

	always_ff @(posedge i_core_clk)
	begin
		if (!i_reset_n)
		begin
			tags_used_q <= '0;
			rx_free_q   <= 8'(`RX_MEM_WORDS);
		end
		else
		begin
			tags_used_q <= tags_used_q + {4'h0, issue} - {4'h0, retire};
			rx_free_q   <= rx_free_q - (issue ? {2'b00, byp_qw} : 8'h00)
				+ {7'h0, deliver};
		end
	end

	// Inbound queue, drained by the dispatcher below
	logic     in_valid;
	in_word_t in_head;
	logic     in_pop;
	disp_t    disp_q;
	logic [3:0] ctag_q;
	logic [6:0] cptr_q;
	logic [6:0] wcnt_q;

	bridge_fifo #(.WIDTH($bits(in_word_t)), .DEPTH(`QUEUE_DEPTH)) u_inq (
		.i_core_clk  (i_core_clk),
		.i_reset_n   (i_reset_n),
		.i_in_valid  (i_in_valid),
		.i_in_data   (i_in_word),
		.o_in_ready  (o_in_ready),
		.o_out_valid (in_valid),
		.o_out_data  (in_head),
		.i_out_ready (in_pop)
	);

	// Tag memory written at issue, counted up as completion words land
	always_ff @(posedge i_core_clk)
	begin
		if (issue)
		begin
			tag_len[tag_ctr_q]  <= byp_qw;
			tag_base[tag_ctr_q] <= rx_alloc_q;
			tag_recv[tag_ctr_q] <= '0;
		end
		if (disp_q == D_CPL && in_pop)
		begin
			rx_mem[cptr_q]   <= in_head.data;
			tag_recv[ctag_q] <= tag_recv[ctag_q] + 6'd1;
		end
	end

	// Only the head tag may return data; freed tag is then reusable
	always_ff @(posedge i_core_clk)
	begin
		if (!i_reset_n)
		begin
			hol_q      <= '0;
			dlv_q      <= '0;
			o_rd_valid <= 1'b0;
			o_rd_data  <= '0;
		end
		else
		begin
			o_rd_valid <= deliver;
			if (deliver)
				o_rd_data <= rx_mem[7'(tag_base[hol_q] + {1'b0, dlv_q})];
			if (retire)
			begin
				hol_q <= hol_q + 4'd1;
				dlv_q <= '0;
			end
			else if (deliver)
				dlv_q <= dlv_q + 6'd1;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Dispatcher: completions, inbound writes, parking of inbound reads

	logic       park_v_q;
	in_hdr_t    park_q;
	logic       accept;
	logic       mw_load;
	logic [7:0] be_first;
	logic [7:0] be_last;
	logic [7:0] be_first_q;
	logic [7:0] be_last_q;
	logic [10:0] end_dw;

	always_comb
	begin
		be_first = in_head.hdr.addr[2] ? {in_head.hdr.first_dword_byte_mask, 4'h0}
			: {4'hf, in_head.hdr.first_dword_byte_mask};
		end_dw = {1'b0, in_head.hdr.len_dw} + {10'h0, in_head.hdr.addr[2]};
		be_last = end_dw[0] ? {4'h0, in_head.hdr.last_dword_byte_mask}
			: {in_head.hdr.last_dword_byte_mask, 4'hf};
		if (qw_of(in_head.hdr.addr, in_head.hdr.len_dw) == 7'd1)
			be_first = in_head.hdr.addr[2] ? {in_head.hdr.first_dword_byte_mask, 4'h0}
				: {in_head.hdr.len_dw == 10'd1 ? 4'h0 : in_head.hdr.last_dword_byte_mask,
				in_head.hdr.first_dword_byte_mask};
	end

	assign mw_load = in_valid && (!o_mw_valid || !i_mw_waitreq);
	always_comb
	begin
		in_pop = 1'b0;
		unique case (disp_q)
			D_HDR:
				if (in_valid)
					in_pop = !in_head.sop || in_head.hdr.kind == TLP_CPL
						|| (in_head.hdr.kind == TLP_WR && !o_mw_valid)
						|| (in_head.hdr.kind == TLP_RD && !park_v_q);
			D_CPL: in_pop = in_valid;
			D_WR:  in_pop = mw_load;
		endcase
	end

	always_ff @(posedge i_core_clk)
	begin
		if (!i_reset_n)
		begin
			disp_q     <= D_HDR;
			ctag_q     <= '0;
			cptr_q     <= '0;
			wcnt_q     <= '0;
			park_v_q   <= 1'b0;
			park_q     <= '0;
			be_first_q <= '0;
			be_last_q  <= '0;
			o_mw_valid <= 1'b0;
			o_mw_addr  <= '0;
			o_mw_burst <= '0;
			o_mw_data  <= '0;
			o_mw_be    <= '0;
		end
		else
		begin
			if (accept)
				park_v_q <= 1'b0;
			if (o_mw_valid && !i_mw_waitreq)
				o_mw_valid <= 1'b0;
			unique case (disp_q)
				D_HDR:
					if (in_pop && in_head.sop)
					begin
						ctag_q <= in_head.hdr.tag[3:0];
						cptr_q <= 7'(tag_base[in_head.hdr.tag[3:0]]
							+ {1'b0, tag_recv[in_head.hdr.tag[3:0]]});
						wcnt_q <= qw_of(in_head.hdr.addr, in_head.hdr.len_dw);
						be_first_q <= be_first;
						be_last_q  <= be_last;
						unique case (in_head.hdr.kind)
							TLP_CPL: disp_q <= in_head.hdr.len_dw[9:1] != '0 ? D_CPL : D_HDR;
							TLP_WR:
							begin
								disp_q     <= D_WR;
								o_mw_addr  <= xlat({in_head.hdr.addr[31:3], 3'b000},
									in_head.hdr.bar);
								o_mw_burst <= qw_of(in_head.hdr.addr, in_head.hdr.len_dw);
								wcnt_q     <= '0;
							end
							TLP_RD:
							begin
								park_v_q <= 1'b1;
								park_q   <= in_head.hdr;
							end
							default: disp_q <= D_HDR;
						endcase
						if (in_head.hdr.kind == TLP_CPL)
							wcnt_q <= 7'(in_head.hdr.len_dw[9:1]);
					end
				D_CPL:
					if (in_pop)
					begin
						cptr_q <= cptr_q + 7'd1;
						wcnt_q <= wcnt_q - 7'd1;
						if (wcnt_q == 7'd1)
							disp_q <= D_HDR;
					end
				D_WR:
					if (mw_load)
					begin
						o_mw_valid <= 1'b1;
						o_mw_data  <= in_head.data;
						o_mw_be    <= wcnt_q == '0 ? be_first_q
							: (wcnt_q + 7'd1 == o_mw_burst ? be_last_q : 8'hff);
						wcnt_q     <= wcnt_q + 7'd1;
						if (wcnt_q + 7'd1 == o_mw_burst)
							disp_q <= D_HDR;
					end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Inbound reads: pending records, bus bursts, completion memory

	pend_rd_t   pend [`PEND_DEPTH];
	logic [1:0] pwr_q;
	logic [1:0] prd_q;
	logic [2:0] pcnt_q;
	logic [7:0] tx_free_q;
	logic [7:0] tx_avail_q;
	logic [6:0] txw_q;
	logic [63:0] tx_mem [`TX_MEM_WORDS];
	logic       mr_busy_q;
	logic [6:0] mr_rem_q;
	logic [6:0] park_qw;
	logic [6:0] mr_next;
	logic       formed;
	logic       sent;
	logic [6:0] csize;

	assign park_qw = qw_of(park_q.addr, park_q.len_dw);
	assign accept = park_v_q && tx_free_q >= {1'b0, park_qw}
		&& pcnt_q != 3'(`PEND_DEPTH) && !mr_busy_q;
	assign mr_next = mr_rem_q > `RD_BURST_QW ? `RD_BURST_QW : mr_rem_q;

	always_ff @(posedge i_core_clk)
	begin
		if (accept)
			pend[pwr_q] <= {park_qw, park_q.addr, park_q.req_id, park_q.tag,
				park_q.first_dword_byte_mask, park_q.last_dword_byte_mask};
		if (formed)
			pend[prd_q].qw <= pend[prd_q].qw - csize;
		if (i_mr_rvalid)
			tx_mem[txw_q] <= i_mr_rdata;
	end

	always_ff @(posedge i_core_clk)
	begin
		if (!i_reset_n)
		begin
			mr_busy_q  <= 1'b0;
			mr_rem_q   <= '0;
			o_mr_valid <= 1'b0;
			o_mr_addr  <= '0;
			o_mr_burst <= '0;
		end
		else if (accept)
		begin
			mr_busy_q <= 1'b1;
			mr_rem_q  <= park_qw;
			o_mr_addr <= xlat({park_q.addr[31:3], 3'b000}, park_q.bar);
		end
		else if (mr_busy_q && !o_mr_valid)
		begin
			o_mr_valid <= 1'b1;
			o_mr_burst <= mr_next;
		end
		else if (o_mr_valid && !i_mr_waitreq)
		begin
			o_mr_valid <= 1'b0;
			o_mr_addr  <= o_mr_addr + {22'h0, o_mr_burst, 3'b000};
			mr_rem_q   <= mr_rem_q - o_mr_burst;
			mr_busy_q  <= mr_rem_q != o_mr_burst;
		end
	end

	always_ff @(posedge i_core_clk)
	begin
		if (!i_reset_n)
		begin
			pwr_q      <= '0;
			prd_q      <= '0;
			pcnt_q     <= '0;
			txw_q      <= '0;
			tx_free_q  <= 8'(`TX_MEM_WORDS);
			tx_avail_q <= '0;
		end
		else
		begin
			pwr_q  <= accept ? pwr_q + 2'd1 : pwr_q;
			prd_q  <= formed && pend[prd_q].qw == csize ? prd_q + 2'd1 : prd_q;
			pcnt_q <= pcnt_q + {2'b00, accept}
				- {2'b00, formed && pend[prd_q].qw == csize};
			txw_q  <= i_mr_rvalid ? txw_q + 7'd1 : txw_q;
			tx_avail_q <= tx_avail_q + {7'h0, i_mr_rvalid}
				- (formed ? {1'b0, csize} : 8'h00);
			tx_free_q  <= tx_free_q - (accept ? {1'b0, park_qw} : 8'h00)
				+ (sent ? {1'b0, o_tc_hdr.len_dw[7:1]} : 8'h00);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Completion send, one payload-sized piece at a time, in pending order

	txs_t       txs_q;
	logic [6:0] txr_q;
	logic [6:0] tcnt_q;

	assign csize = pend[prd_q].qw > MPS_QW ? MPS_QW : pend[prd_q].qw;
	assign formed = txs_q == T_IDLE && pcnt_q != '0 && tx_avail_q >= {1'b0, csize}
		&& i_cpl_hdr_credit && i_cpl_data_credit >= {1'b0, 7'((csize + 7'd1) >> 1)}
		&& (!o_tc_valid || i_tc_ready);
	assign sent = txs_q == T_DATA && tcnt_q == '0 && (!o_tc_valid || i_tc_ready);

	always_ff @(posedge i_core_clk)
	begin
		if (!i_reset_n)
		begin
			txs_q      <= T_IDLE;
			txr_q      <= '0;
			tcnt_q     <= '0;
			o_tc_valid <= 1'b0;
			o_tc_sop   <= 1'b0;
			o_tc_hdr   <= '0;
			o_tc_data  <= '0;
		end
		else
		begin
			if (o_tc_valid && i_tc_ready)
				o_tc_valid <= 1'b0;
			if (formed)
			begin
				txs_q      <= T_DATA;
				tcnt_q     <= csize;
				o_tc_valid <= 1'b1;
				o_tc_sop   <= 1'b1;
				o_tc_hdr   <= {pend[prd_q].req_id, pend[prd_q].tag, {2'b00, csize, 1'b0},
					{2'b00, pend[prd_q].qw, 3'b000}, pend[prd_q].addr[6:0]};
			end
			else if (sent)
				txs_q <= T_IDLE;
			else if (txs_q == T_DATA && (!o_tc_valid || i_tc_ready))
			begin
				o_tc_valid <= 1'b1;
				o_tc_sop   <= 1'b0;
				o_tc_data  <= tx_mem[txr_q];
				txr_q      <= txr_q + 7'd1;
				tcnt_q     <= tcnt_q - 7'd1;
			end
		end
	end
endmodule // membus_bridge

// File: verilog/membus_bridge_map.svh
/*
 * Constants of the bridge data path: size limits, memory depths, table layout.
 * Assumes it is included by the package and the top module by bare name.
 */
`ifndef MEMBUS_BRIDGE_MAP_SVH
`define MEMBUS_BRIDGE_MAP_SVH

`define RQ_MAX_BYTES   13'h0100
`define ADDR_BOUNDARY  13'h1000
`define TAG_COUNT      16
`define RX_MEM_WORDS   128
`define TX_MEM_WORDS   128
`define RD_BURST_QW    7'h40
`define MPS_BYTES      128
`define XLAT_KEEP_BITS 20
`define XLAT_ENTRIES   6
`define QUEUE_DEPTH    16
`define PEND_DEPTH     4

`endif

// File: verilog/membus_bridge_pkg.sv
/*
 * Types shared by the bridge data path and its bench.
 * Assumes membus_bridge_map.svh is on the include path.
 */
package membus_bridge_pkg;
`include "membus_bridge_map.svh"

	typedef enum logic [1:0] {TLP_CPL, TLP_WR, TLP_RD} tlp_kind_t;

	// Reduced inbound header; tag low nibble is the completion tag
	typedef struct packed {
		tlp_kind_t   kind;
		logic [2:0]  bar;
		logic [7:0]  tag;
		logic [15:0] req_id;
		logic [3:0]  first_dword_byte_mask;
		logic [3:0]  last_dword_byte_mask;
		logic [9:0]  len_dw;
		logic [31:0] addr;
	} in_hdr_t;

	typedef struct packed {
		logic        sop;
		in_hdr_t     hdr;
		logic [63:0] data;
	} in_word_t;

	typedef struct packed {
		logic [31:0] addr;
		logic [9:0]  len_dw;
		logic [3:0]  tag;
	} rd_req_t;

	typedef struct packed {
		logic [15:0] req_id;
		logic [7:0]  tag;
		logic [9:0]  len_dw;
		logic [11:0] byte_count;
		logic [6:0]  lower_addr;
	} cpl_hdr_t;

	typedef struct packed {
		logic [6:0]  qw;
		logic [31:0] addr;
		logic [15:0] req_id;
		logic [7:0]  tag;
		logic [3:0]  first_dword_byte_mask;
		logic [3:0]  last_dword_byte_mask;
	} pend_rd_t;
endpackage
